/* File: rtl/hash_sel_pkg.sv */
// shared constants and carrier types for the receive hash field selector
package hash_sel_pkg;

  // enabled-hash-type bit positions; report code is position plus one
  localparam int HT_V4_ADDR = 0;
  localparam int HT_V4_TCP = 1;
  localparam int HT_V4_UDP = 2;
  localparam int HT_V6_ADDR = 3;
  localparam int HT_V6_TCP = 4;
  localparam int HT_V6_UDP = 5;
  localparam int HT_V6X_ADDR = 6;
  localparam int HT_V6X_TCP = 7;
  localparam int HT_V6X_UDP = 8;
  localparam int HT_W = 9;
  localparam logic [3:0] RPT_NONE = 4'h0;

  // encapsulation bit positions of the inner-hash mask
  localparam int ENC_GRE_A = 0;
  localparam int ENC_GRE_B = 1;
  localparam int ENC_GRE_C = 2;
  localparam int ENC_GRE_UDP = 3;
  localparam int ENC_VXLAN = 4;
  localparam int ENC_VXLAN_GPE = 5;
  localparam int ENC_GENEVE = 6;
  localparam int ENC_IPIP = 7;
  localparam int ENC_NVGRE = 8;
  localparam int ENC_W = 9;
  localparam logic [31:0] TUN_SUPPORTED = 32'h0000_01ff;

  // control command codes and acknowledgement values
  localparam logic [7:0] CLS_TUNNEL = 8'h07;
  localparam logic [7:0] CMD_TUNNEL_SET = 8'h00;
  localparam logic ACK_OK = 1'b0;
  localparam logic ACK_ERR = 1'b1;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_HASH_TYPES = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_CMD_DATA = 8'h0c;
  localparam logic [7:0] OFF_CMD_GO = 8'h10;
  localparam logic [7:0] OFF_CMD_STAT = 8'h14;
  localparam logic [7:0] OFF_TUN_EN = 8'h18;
  localparam logic [7:0] OFF_TUN_SUP = 8'h1c;
  localparam logic [7:0] OFF_HASHED = 8'h20;

  // field positions and reset values
  localparam int CTRL_TUN_NEG = 0;
  localparam int CTRL_RPT_NEG = 1;
  localparam int STAT_ACK = 0;
  localparam int STAT_DONE = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [8:0] TYPES_RST = 9'h000;
  localparam logic [8:0] TUN_EN_RST = 9'h000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // parsed header; ipv4 addresses sit in the low 32 bits
  typedef struct packed {
    logic is_v4;
    logic is_v6;
    logic has_ext;
    logic has_tcp;
    logic has_udp;
    logic [127:0] src;
    logic [127:0] dst;
    logic [15:0] sport;
    logic [15:0] dport;
    logic home_vld;
    logic [127:0] home;
    logic rt2_vld;
    logic [127:0] rt2;
  } hdr_t;

  // one received packet, outer and single inner header
  typedef struct packed {
    logic valid;
    logic [8:0] encap;
    hdr_t outer;
    hdr_t inner;
  } pkt_t;

  // fields handed to the hash engine, in hash order
  typedef struct packed {
    logic valid;
    logic [3:0] rtype;
    logic v6;
    logic ports;
    logic [127:0] src;
    logic [127:0] dst;
    logic [15:0] sport;
    logic [15:0] dport;
  } sel_t;

endpackage

/* File: rtl/field_pick.sv */
// combinational choice of hash fields for one header
`timescale 1ns/1ps
module field_pick (
  input wire hash_sel_pkg::hdr_t hdr,
  input wire logic [8:0] types,
  output hash_sel_pkg::sel_t sel
);
  logic hit;
  logic ports;
  int idx;
  logic [127:0] sa;
  logic [127:0] da;

  always_comb begin
    hit = 1'b0;
    ports = 1'b0;
    idx = 0;
    sa = hdr.src;
    da = hdr.dst;
    if (hdr.is_v4) begin
      // R03 tcp first
      if (hdr.has_tcp && types[hash_sel_pkg::HT_V4_TCP]) begin
        hit = 1'b1;
        ports = 1'b1;
        idx = hash_sel_pkg::HT_V4_TCP;
      // R04 then udp
      end else if (hdr.has_udp && types[hash_sel_pkg::HT_V4_UDP]) begin
        hit = 1'b1;
        ports = 1'b1;
        idx = hash_sel_pkg::HT_V4_UDP;
      // R05 addresses or nothing
      end else if (types[hash_sel_pkg::HT_V4_ADDR]) begin
        hit = 1'b1;
        idx = hash_sel_pkg::HT_V4_ADDR;
      end
    end else if (hdr.is_v6) begin
      if (hdr.has_ext) begin
        // R08 home and routing substitution
        sa = hdr.home_vld ? hdr.home : hdr.src;
        da = hdr.rt2_vld ? hdr.rt2 : hdr.dst;
        // R09 extended tcp then udp
        if (hdr.has_tcp && types[hash_sel_pkg::HT_V6X_TCP]) begin
          hit = 1'b1;
          ports = 1'b1;
          idx = hash_sel_pkg::HT_V6X_TCP;
        end else if (hdr.has_udp && types[hash_sel_pkg::HT_V6X_UDP]) begin
          hit = 1'b1;
          ports = 1'b1;
          idx = hash_sel_pkg::HT_V6X_UDP;
        // R10 extended address only
        end else if (types[hash_sel_pkg::HT_V6X_ADDR]) begin
          hit = 1'b1;
          idx = hash_sel_pkg::HT_V6X_ADDR;
        end
      end
      // R10 skip extensions, plain selection
      if (!hit) begin
        sa = hdr.src;
        da = hdr.dst;
        // R06 tcp then udp
        if (hdr.has_tcp && types[hash_sel_pkg::HT_V6_TCP]) begin
          hit = 1'b1;
          ports = 1'b1;
          idx = hash_sel_pkg::HT_V6_TCP;
        end else if (hdr.has_udp && types[hash_sel_pkg::HT_V6_UDP]) begin
          hit = 1'b1;
          ports = 1'b1;
          idx = hash_sel_pkg::HT_V6_UDP;
        // R07 addresses or nothing
        end else if (types[hash_sel_pkg::HT_V6_ADDR]) begin
          hit = 1'b1;
          idx = hash_sel_pkg::HT_V6_ADDR;
        end
      end
    end
    sel = '0;
    // R20 zero fields and no valid without a hash
    if (hit) begin
      sel.valid = 1'b1;
      // R19 code is bit index plus one
      sel.rtype = 4'(idx + 1);
      sel.v6 = hdr.is_v6;
      sel.ports = ports;
      sel.src = sa;
      sel.dst = da;
      sel.sport = ports ? hdr.sport : 16'h0000;
      sel.dport = ports ? hdr.dport : 16'h0000;
    end
  end
endmodule

/* File: rtl/tunnel_cfg.sv */
// executes the inner-hash configuration command and holds its mask
`timescale 1ns/1ps
module tunnel_cfg (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic tun_neg,
  input wire logic [15:0] cmd_word,
  input wire logic [31:0] payload,
  input wire logic done_clr,
  output logic [8:0] enabled,
  output logic ack,
  output logic done
);
  typedef struct packed {
    logic [8:0] enabled;
    logic ack;
    logic done;
  } tun_state_t;

  tun_state_t r;
  tun_state_t next_r;
  logic bad;

  always_comb begin
    // R11 only class 7 command 0 is known
    bad = (cmd_word[7:0] != hash_sel_pkg::CLS_TUNNEL) || (cmd_word[15:8] != hash_sel_pkg::CMD_TUNNEL_SET) ||
          !tun_neg;
    // R16 unsupported bits refused
    bad = bad || ((payload & ~hash_sel_pkg::TUN_SUPPORTED) != 32'h0000_0000);
    next_r = r;
    if (done_clr) begin
      next_r.done = 1'b0;
    end
    // completion set wins over a same-cycle clear
    if (go) begin
      next_r.done = 1'b1;
      next_r.ack = bad ? hash_sel_pkg::ACK_ERR : hash_sel_pkg::ACK_OK;
      // R15 zero mask disables every type
      if (!bad) begin
        next_r.enabled = payload[8:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // R15 all types off after reset
      r.enabled <= hash_sel_pkg::TUN_EN_RST;
      r.ack <= hash_sel_pkg::ACK_OK;
      r.done <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign enabled = r.enabled;
  assign ack = r.ack;
  assign done = r.done;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_unsup_refused: assert property (go && ((payload & ~hash_sel_pkg::TUN_SUPPORTED) != 32'h0) // R16
    |=> ack == hash_sel_pkg::ACK_ERR && enabled == $past(enabled)) else $error("unsupported mask accepted");
  a_zero_disables: assert property (go && !bad && payload == 32'h0 |=> enabled == 9'h000 ##1 // R15
    (enabled == 9'h000 || $past(go))) else $error("zero mask left types on");
  a_cmd_code: assert property (go && tun_neg && cmd_word[7:0] != hash_sel_pkg::CLS_TUNNEL // R11
    |=> ack == hash_sel_pkg::ACK_ERR && done) else $error("wrong class accepted");
endmodule

/* File: rtl/hash_field_select.sv */
// receive hash field selector with its ahb-lite register file
`timescale 1ns/1ps

// How it works
// R01: v6 plain types at bits 3-5
// R02: v6 extension types at bits 6-8
// R03: v4 tcp enabled: addresses then tcp ports
// R04: else v4 udp enabled: addresses, udp ports
// R05: else v4 addresses if enabled, else none
// R06: v6 plain: tcp first, then udp
// R07: else v6 addresses if enabled, else none
// R08: extension: home and routing addresses substitute
// R09: extension: tcp, then udp with substitutes
// R10: else substitutes only, else plain v6
// R11: class 7 command 0 carries mask unchanged
// R12: encapsulation bits 0 to 8 fixed
// R13: enabled tunnel match hashes inner header
// R14: no enabled match hashes outer header
// R15: zero mask or reset disables inner
// R16: unsupported mask bits answered with error
// R17: v4 types at bits 0-2
// R18: driver never enables unsupported types
// R19: report none or bit index plus one
// R20: fields, valid and code to engine
module hash_field_select (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire hash_sel_pkg::pkt_t pkt,
  output hash_sel_pkg::sel_t out_sel,
  output logic rpt_valid,
  output logic [3:0] rpt_code
);
  typedef struct packed {
    logic [1:0] ctrl;
    logic [8:0] types;
    logic [15:0] cmd;
    logic [31:0] cmd_data;
    logic go;
    logic done_clr;
    logic [7:0] addr;
    logic addr_ok;
    logic wr;
    logic rd_wait;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] hashed;
    hash_sel_pkg::sel_t out;
    logic rpt_valid;
    logic [3:0] rpt_code;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic [8:0] tun_en;
  logic tun_ack;
  logic tun_done;
  logic use_inner;
  hash_sel_pkg::hdr_t hs;
  hash_sel_pkg::sel_t pick;
  logic [31:0] rd_mux;

  tunnel_cfg u_tunnel (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(r.go),
    .tun_neg(r.ctrl[hash_sel_pkg::CTRL_TUN_NEG]),
    .cmd_word(r.cmd),
    .payload(r.cmd_data),
    .done_clr(r.done_clr),
    .enabled(tun_en),
    .ack(tun_ack),
    .done(tun_done)
  );

  always_comb begin
    // R12 encap bit i matches mask bit i
    // R13 inner header on an enabled match
    use_inner = r.ctrl[hash_sel_pkg::CTRL_TUN_NEG] && ((pkt.encap & tun_en) != 9'h000);
    // R14 otherwise the outer header
    hs = use_inner ? pkt.inner : pkt.outer;
  end

  field_pick u_pick (
    .hdr(hs),
    .types(r.types),
    .sel(pick)
  );

  always_comb begin
    case (r.addr)
      hash_sel_pkg::OFF_CTRL: rd_mux = {30'h0, r.ctrl};
      hash_sel_pkg::OFF_HASH_TYPES: rd_mux = {23'h0, r.types};
      hash_sel_pkg::OFF_CMD: rd_mux = {16'h0, r.cmd};
      hash_sel_pkg::OFF_CMD_DATA: rd_mux = r.cmd_data;
      hash_sel_pkg::OFF_CMD_STAT: rd_mux = {30'h0, tun_done, tun_ack};
      hash_sel_pkg::OFF_TUN_EN: rd_mux = {23'h0, tun_en};
      hash_sel_pkg::OFF_TUN_SUP: rd_mux = hash_sel_pkg::TUN_SUPPORTED;
      hash_sel_pkg::OFF_HASHED: rd_mux = r.hashed;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (!r.addr_ok) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_comb begin
    next_r = r;
    next_r.go = 1'b0;
    next_r.done_clr = 1'b0;
    next_r.hresp = 1'b0;
    // write data phase; unmapped writes are dropped
    if (r.wr) begin
      next_r.wr = 1'b0;
      if (r.addr_ok) begin
        case (r.addr)
          hash_sel_pkg::OFF_CTRL: next_r.ctrl = hwdata[1:0];
          // R01 R02 R17 one mask bit per type
          hash_sel_pkg::OFF_HASH_TYPES: next_r.types = hwdata[8:0];
          hash_sel_pkg::OFF_CMD: next_r.cmd = hwdata[15:0];
          // R11 payload word kept exactly as written
          hash_sel_pkg::OFF_CMD_DATA: next_r.cmd_data = hwdata;
          hash_sel_pkg::OFF_CMD_GO: next_r.go = 1'b1;
          hash_sel_pkg::OFF_CMD_STAT: next_r.done_clr = hwdata[hash_sel_pkg::STAT_DONE];
          default: ;
        endcase
      end
    end
    // one wait state so read data leave a flop
    if (r.rd_wait) begin
      next_r.rd_wait = 1'b0;
      next_r.hreadyout = 1'b1;
      next_r.hrdata = rd_mux;
    end
    if (hsel && htrans[1] && hready) begin
      next_r.addr = haddr[7:0];
      next_r.addr_ok = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);
      next_r.wr = hwrite;
      if (!hwrite) begin
        next_r.rd_wait = 1'b1;
        next_r.hreadyout = 1'b0;
      end
    end
    // R20 one registered beat per packet
    next_r.out = pkt.valid ? pick : '0;
    // R19 code reported even when no hash
    next_r.rpt_valid = pkt.valid && r.ctrl[hash_sel_pkg::CTRL_RPT_NEG];
    next_r.rpt_code = pkt.valid ? pick.rtype : hash_sel_pkg::RPT_NONE;
    if (pkt.valid && pick.valid) begin
      next_r.hashed = r.hashed + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.ctrl <= hash_sel_pkg::CTRL_RST;
      r.types <= hash_sel_pkg::TYPES_RST;
      r.hreadyout <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign out_sel = r.out;
  assign rpt_valid = r.rpt_valid;
  assign rpt_code = r.rpt_code;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_accept;
    hsel && htrans == hash_sel_pkg::HTRANS_NONSEQ && hready && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (rd_accept |=> rd_answer) else $error("read not answered after one wait");
  a_v4_tcp_first: assert property (pkt.valid && hs.is_v4 && hs.has_tcp && r.types[hash_sel_pkg::HT_V4_TCP] // R03
    |=> out_sel.valid && out_sel.rtype == 4'h2 && out_sel.sport == $past(hs.sport)) else $error("v4 tcp not chosen");
  a_v4_udp_next: assert property (pkt.valid && hs.is_v4 && hs.has_udp && !hs.has_tcp // R04
    && r.types[hash_sel_pkg::HT_V4_UDP] |=> out_sel.rtype == 4'h3 && out_sel.dport == $past(hs.dport))
    else $error("v4 udp not chosen");
  a_v4_no_hash: assert property (pkt.valid && hs.is_v4 && r.types[2:0] == 3'h0 // R05
    |=> !out_sel.valid && out_sel.rtype == hash_sel_pkg::RPT_NONE) else $error("v4 hashed while disabled");
  a_v6_udp_pick: assert property (pkt.valid && hs.is_v6 && !hs.has_ext && hs.has_udp && !hs.has_tcp // R06
    && r.types[hash_sel_pkg::HT_V6_UDP] |=> out_sel.rtype == 4'h6 && out_sel.ports) else $error("v6 udp not chosen");
  a_v6_addr_only: assert property (pkt.valid && hs.is_v6 && !hs.has_ext && !hs.has_tcp && !hs.has_udp // R07
    && r.types[hash_sel_pkg::HT_V6_ADDR] |=> out_sel.rtype == 4'h4 && !out_sel.ports && out_sel.dst == $past(hs.dst))
    else $error("v6 address hash wrong");
  a_home_subst: assert property (pkt.valid && hs.is_v6 && hs.has_ext && hs.home_vld // R08
    && r.types[hash_sel_pkg::HT_V6X_ADDR] |=> out_sel.src == $past(hs.home)) else $error("home address not used");
  a_ext_fallback: assert property (pkt.valid && hs.is_v6 && hs.has_ext && r.types[8:6] == 3'h0 // R10
    && !hs.has_tcp && !hs.has_udp
    && r.types[hash_sel_pkg::HT_V6_ADDR] |=> out_sel.rtype == 4'h4 && out_sel.src == $past(hs.src))
    else $error("extension fallback wrong");
  a_inner_used: assert property (pkt.valid && use_inner && pkt.inner.is_v6 && !pkt.inner.has_ext // R13
    && r.types[hash_sel_pkg::HT_V6_ADDR] |=> out_sel.src == $past(pkt.inner.src)) else $error("inner header ignored");
  a_outer_used: assert property (pkt.valid && (pkt.encap & tun_en) == 9'h000 && pkt.outer.is_v4 // R14
    && r.types[hash_sel_pkg::HT_V4_ADDR] |=> out_sel.src == $past(pkt.outer.src)) else $error("outer header ignored");
  a_report_code: assert property (pkt.valid && r.ctrl[hash_sel_pkg::CTRL_RPT_NEG] // R19
    |=> rpt_valid && rpt_code == out_sel.rtype) else $error("report code mismatch");
  a_none_idle: assert property (!out_sel.valid |-> out_sel.rtype == hash_sel_pkg::RPT_NONE // R20
    && out_sel.src == 128'h0) else $error("fields shown without hash");
endmodule

/* File: rtl/dummy_unused_placeholder_removed.sv */
// intentionally empty of logic: holds no module
`timescale 1ns/1ps

/* File: testbench/drv_model.sv */
// driver-side model: ahb-lite master that issues control commands
`timescale 1ns/1ps
module drv_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // each phase held until hready is seen high; no latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= hash_sel_pkg::HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  // callers pass unsupported bits only on purpose
  task automatic tun_cmd(input logic [7:0] cls, input logic [31:0] mask, output logic [31:0] stat);
    logic [31:0] q;
    xfer(1'b1, hash_sel_pkg::OFF_CMD, {16'h0000, hash_sel_pkg::CMD_TUNNEL_SET, cls}, q);
    xfer(1'b1, hash_sel_pkg::OFF_CMD_DATA, mask, q);
    xfer(1'b1, hash_sel_pkg::OFF_CMD_GO, 32'h1, q);
    xfer(1'b0, hash_sel_pkg::OFF_CMD_STAT, 32'h0, stat);
  endtask
endmodule

/* File: testbench/test_rx_packet_hash_field_select.sv */
// self-checking bench for the receive hash field selector
`timescale 1ns/1ps
module test_rx_packet_hash_field_select;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  hash_sel_pkg::pkt_t pkt;
  hash_sel_pkg::sel_t out_sel;
  logic rpt_valid;
  logic [3:0] rpt_code;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  hash_field_select u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pkt(pkt), .out_sel(out_sel),
    .rpt_valid(rpt_valid), .rpt_code(rpt_code)
  );

  drv_model u_drv (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang ends the run well past the few hundred cycles needed
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_drv.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_drv.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk(hresp, 1'b0);
  endtask

  function automatic hash_sel_pkg::hdr_t hdr(input logic v4, ext, tcp, udp, input logic [7:0] b);
    hash_sel_pkg::hdr_t h;
    h = '0;
    h.is_v4 = v4;
    h.is_v6 = !v4;
    h.has_ext = ext;
    h.has_tcp = tcp;
    h.has_udp = udp;
    h.src = {120'h0, b};
    h.dst = {120'h0, b + 8'h01};
    h.sport = {8'h11, b};
    h.dport = {8'h22, b};
    h.home_vld = 1'b1;
    h.home = {120'h0, b + 8'h02};
    h.rt2_vld = tcp;
    h.rt2 = {120'h0, b + 8'h03};
    return h;
  endfunction

  function automatic hash_sel_pkg::pkt_t mkpkt(input logic [8:0] encap);
    hash_sel_pkg::pkt_t p;
    p = '0;
    p.valid = 1'b1;
    p.encap = encap;
    p.outer = hdr(1'b1, 1'b0, 1'b1, 1'b0, 8'h10);
    p.inner = hdr(1'b0, 1'b0, 1'b0, 1'b1, 8'h40);
    return p;
  endfunction

  task automatic send(input hash_sel_pkg::pkt_t p);
    @(posedge hclk);
    pkt <= p;
    @(posedge hclk);
    pkt <= '0;
    #1;
  endtask

  // extension codes 7..9 use home and routing substitutes when present
  task automatic chk_sel(input hash_sel_pkg::hdr_t h, input logic [3:0] code, input logic rv);
    logic x;
    logic pt;
    x = code >= 4'h7;
    pt = code != 4'h0 && code % 4'h3 != 4'h1;
    chk(rpt_code, code);
    chk(rpt_valid, rv);
    chk(out_sel.valid, code != 4'h0);
    chk(out_sel.rtype, code);
    chk(out_sel.v6, code >= 4'h4);
    chk(out_sel.ports, pt);
    chk(out_sel.src, code == 4'h0 ? 128'h0 : (x && h.home_vld ? h.home : h.src));
    chk(out_sel.dst, code == 4'h0 ? 128'h0 : (x && h.rt2_vld ? h.rt2 : h.dst));
    chk(out_sel.sport, pt ? h.sport : 16'h0);
    chk(out_sel.dport, pt ? h.dport : 16'h0);
  endtask

  task automatic t_reset();
    rd_chk(hash_sel_pkg::OFF_HASH_TYPES, 32'h0);
    rd_chk(hash_sel_pkg::OFF_TUN_EN, 32'h0);
    rd_chk(hash_sel_pkg::OFF_TUN_SUP, hash_sel_pkg::TUN_SUPPORTED);
    rd_chk(hash_sel_pkg::OFF_CMD_STAT, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask

  // row: types, v4, ext, tcp, udp, expected code
  task automatic t_types();
    logic [16:0] tbl [13];
    hash_sel_pkg::pkt_t p;
    tbl = '{{9'h1ff, 4'b1010, 4'h2}, {9'h1ff, 4'b1001, 4'h3}, {9'h001, 4'b1010, 4'h1},
      {9'h004, 4'b1010, 4'h0}, {9'h1ff, 4'b0010, 4'h5}, {9'h1ff, 4'b0001, 4'h6},
      {9'h008, 4'b0010, 4'h4}, {9'h030, 4'b0000, 4'h0}, {9'h1ff, 4'b0110, 4'h8},
      {9'h1ff, 4'b0101, 4'h9}, {9'h040, 4'b0101, 4'h7}, {9'h008, 4'b0100, 4'h4}, {9'h010, 4'b0110, 4'h5}};
    for (int i = 0; i < 13; i++) begin
      if (i == 1) begin
        wr(hash_sel_pkg::OFF_CTRL, 32'h2);
      end
      wr(hash_sel_pkg::OFF_HASH_TYPES, {23'h0, tbl[i][16:8]});
      p = '0;
      p.valid = 1'b1;
      p.outer = hdr(tbl[i][7], tbl[i][6], tbl[i][5], tbl[i][4], 8'h20);
      send(p);
      chk_sel(p.outer, tbl[i][3:0], i != 0);
    end
    rd_chk(hash_sel_pkg::OFF_HASH_TYPES, 32'h010);
    rd_chk(hash_sel_pkg::OFF_HASHED, 32'd11);
  endtask

  task automatic t_tunnel();
    logic [31:0] q;
    hash_sel_pkg::pkt_t p;
    wr(hash_sel_pkg::OFF_CTRL, 32'h3);
    wr(hash_sel_pkg::OFF_HASH_TYPES, 32'h1ff);
    for (int i = 0; i < 9; i++) begin
      u_drv.tun_cmd(hash_sel_pkg::CLS_TUNNEL, 32'h1 << i, q);
      chk(q, 32'h2);
      rd_chk(hash_sel_pkg::OFF_TUN_EN, 32'h1 << i);
      p = mkpkt(9'h001 << i);
      send(p);
      chk_sel(p.inner, 4'h6, 1'b1);
      p = mkpkt(9'h001 << ((i + 1) % 9));
      send(p);
      chk_sel(p.outer, 4'h2, 1'b1);
    end
    u_drv.tun_cmd(hash_sel_pkg::CLS_TUNNEL, 32'h200, q);
    chk(q, 32'h3);
    rd_chk(hash_sel_pkg::OFF_TUN_EN, 32'h100);
    u_drv.tun_cmd(8'h06, 32'h1, q);
    chk(q, 32'h3);
    u_drv.tun_cmd(hash_sel_pkg::CLS_TUNNEL, 32'h0, q);
    chk(q, 32'h2);
    rd_chk(hash_sel_pkg::OFF_TUN_EN, 32'h0);
    p = mkpkt(9'h100);
    send(p);
    chk_sel(p.outer, 4'h2, 1'b1);
    wr(hash_sel_pkg::OFF_CMD_STAT, 32'h2);
    rd_chk(hash_sel_pkg::OFF_CMD_STAT, 32'h0);
  endtask

  initial begin
    hresetn = 1'b0;
    pkt = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_types();
    t_tunnel();
    end_of_test();
  end
endmodule
